//--- inc/acc_if.sv
// Interface joining the converter end and the bus master end
`timescale 1ns/1ns
interface acc_if;
  import acc_pkg::*;
  logic              power_down_n;       // Low puts the converter in power-down
  logic              chip_select_n;      // Select, also picks nap or sleep
  logic              read_n;             // Output read strobe
  logic              conversion_start_n; // Falling edge starts a conversion
  logic              busy_n;             // Low while converting
  logic [DATA_W-1:0] data_out;           // Result from converter
  logic              data_oe;            // Converter drives data pins
  logic [DATA_W-1:0] data_bus;           // Level seen on the data wires

  assign data_bus = data_oe ? data_out : '0;

  modport device (
    input  power_down_n, chip_select_n, read_n, conversion_start_n,
    output busy_n, data_out, data_oe
  );
  modport host (
    output power_down_n, chip_select_n, read_n, conversion_start_n,
    input  busy_n, data_bus, data_oe
  );
endinterface : acc_if

//--- inc/acc_pkg.sv
// Package for the converter control block: timing counts, widths and enumerations
package acc_pkg;
  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int CONV_TYP_NS      = 1800;
  localparam int CONV_MAX_NS      = 2200;
  localparam int NAP_WAKE_NS      = 400;
  localparam int SLEEP_WAKE_MS    = 20;
  localparam int CONV_CYCLES      = CONV_TYP_NS / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYCLES  = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int NAP_WAKE_CYCLES  = (NAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_WAKE_CYCLES = (SLEEP_WAKE_MS * 1000000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
  localparam int CNT_W            = 21;
  // ------------------------------------------------------------
  // Data
  // ------------------------------------------------------------
  localparam int DATA_W           = 14;
  localparam logic [DATA_W-1:0] DATA_RESET = 14'h0000;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_PWR_ACTIVE,
    ACC_PWR_NAP,
    ACC_PWR_SLEEP
  } acc_pwr_t;

  typedef enum logic [1:0] {
    ACC_MODE_FREE,
    ACC_MODE_READ,
    ACC_MODE_SLOWMEM,
    ACC_MODE_ROM
  } acc_mode_t;
endpackage : acc_pkg

//--- logic/acc_device.sv
// Converter end: conversion sequencing, busy, output gating and power-down
`timescale 1ns/1ns
// Behaviour
// RULE1: Nap powers down all but logic, reference
// RULE2: Nap wake takes 400 ns before ready
// RULE3: Sleep also shuts the reference down
// RULE4: Host waits 20 ms after sleep
// RULE5: Power-down while power_down_n low
// RULE6: Chip select at entry picks nap or sleep
// RULE7: Start low with select low starts conversion
// RULE8: Falling start edge starts conversion
// RULE9: Starts ignored during a conversion
// RULE10: Busy low for whole conversion
// RULE11: Select and read low drive data continuously
// RULE12: Data tristated unless read asserted
// RULE13: Slow memory and ROM tie strobes
// RULE14: Slow memory host holds strobe until busy
// RULE15: Previous result shown while converting
// RULE16: New result shown before busy rises (here the result updates on the same edge that busy rises)
// RULE17: ROM strobe starts and reads previous
// RULE18: ROM host waits for completion
// RULE19: Conversion ends within 2.2 us
// RULE20: Result is 14-bit two's complement
// RULE21: Drive data only with select and read low
module acc_device
  import acc_pkg::*;
#(
  parameter int CONV_LEN  = CONV_CYCLES,       // Conversion length in cycles
  parameter int NAP_WAKE  = NAP_WAKE_CYCLES,   // Nap wake-up in cycles
  parameter int SLEEP_WAKE = SLEEP_WAKE_CYCLES // Sleep wake-up in cycles
) (
  input  wire logic                 sys_clk,       // System clock
  input  wire logic                 rst_n,         // Synchronous reset, active low
  acc_if.device                     link,          // Pins toward the bus master
  input  wire logic signed [acc_pkg::DATA_W-1:0] sample_in, // Quantised sample, two's complement
  output logic                      sample_take,   // Pulse when the sample is held
  output logic                      ref_on,        // Reference powered
  output logic                      analog_on,     // Analog core powered
  output logic                      ready          // Wake-up complete
);
  import acc_pkg::*;

  // ------------------------------------------------------------
  // Start detection and power decode
  // ------------------------------------------------------------
  logic              start_q;
  logic              converting;
  logic [CNT_W-1:0]  conv_cnt;
  logic [CNT_W-1:0]  wake_cnt;
  logic [DATA_W-1:0] result;
  acc_pwr_t          pwr;
  logic              busy_n_q;
  logic              oe_q;

  wire start_fall  = start_q && !link.conversion_start_n;
  wire selected    = !link.chip_select_n;
  wire powered     = link.power_down_n && (pwr == ACC_PWR_ACTIVE) && ready;
  wire start_req   = start_fall && selected && powered && !converting; // RULE7 RULE8 RULE9
  wire conv_done   = converting && (conv_cnt == CNT_W'(CONV_LEN - 1));   // RULE19
  wire drive_data  = selected && !link.read_n;                          // RULE21 RULE11 RULE12
  wire enter_down  = !link.power_down_n && (pwr == ACC_PWR_ACTIVE);     // RULE5
  wire wake_done   = wake_cnt == '0;

  // ------------------------------------------------------------
  // Power state
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pwr      <= ACC_PWR_ACTIVE;
      ready    <= 1'b1;
      wake_cnt <= '0;
    end else if (enter_down) begin
      pwr   <= selected ? ACC_PWR_NAP : ACC_PWR_SLEEP; // RULE6
      ready <= 1'b0;
    end else if (link.power_down_n && pwr != ACC_PWR_ACTIVE) begin
      // Wake time depends on whether the reference was off
      wake_cnt <= (pwr == ACC_PWR_NAP) ? CNT_W'(NAP_WAKE) : CNT_W'(SLEEP_WAKE); // RULE2 RULE4
      pwr      <= ACC_PWR_ACTIVE;
    end else if (pwr == ACC_PWR_ACTIVE && !ready) begin
      if (wake_done) begin
        ready <= 1'b1;
      end else begin
        wake_cnt <= wake_cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      analog_on <= 1'b1;
      ref_on    <= 1'b1;
    end else begin
      analog_on <= link.power_down_n && !enter_down && pwr == ACC_PWR_ACTIVE; // RULE1
      ref_on    <= pwr != ACC_PWR_SLEEP && !(enter_down && !selected);      // RULE3
    end
  end

  // ------------------------------------------------------------
  // Conversion sequencing
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      start_q <= 1'b1;
    end else begin
      start_q <= link.conversion_start_n;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      converting  <= 1'b0;
      conv_cnt    <= '0;
      busy_n_q    <= 1'b1;
      sample_take <= 1'b0;
    end else begin
      sample_take <= start_req;
      if (start_req) begin
        converting <= 1'b1;
        conv_cnt   <= '0;
        busy_n_q   <= 1'b0; // RULE10
      end else if (conv_done) begin
        converting <= 1'b0;
        busy_n_q   <= 1'b1; // RULE10 RULE16
      end else if (converting) begin
        conv_cnt <= conv_cnt + CNT_W'(1);
      end
    end
  end

  // Result updates the same edge busy rises, so data is valid at that edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      result <= DATA_RESET;
    end else if (conv_done) begin
      result <= sample_in; // RULE20 RULE16
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= drive_data; // RULE21
    end
  end

  // Old result stays on the pins while converting
  assign link.data_out = result; // RULE15 RULE17
  assign link.data_oe  = oe_q;
  assign link.busy_n   = busy_n_q;
endmodule : acc_device

//--- logic/acc_host.sv
// Bus master end: drives strobes in the four connection modes
`timescale 1ns/1ns
module acc_host
  import acc_pkg::*;
#(
  parameter int NAP_WAKE   = NAP_WAKE_CYCLES,   // Wait after nap exit
  parameter int SLEEP_WAKE = SLEEP_WAKE_CYCLES, // Wait after sleep exit
  parameter int PULSE_LEN  = 4                  // Strobe width in cycles
) (
  input  wire logic              sys_clk,    // System clock
  input  wire logic              rst_n,      // Synchronous reset, active low
  acc_if.host                    link,       // Pins toward the converter
  input  wire acc_pkg::acc_mode_t mode,      // Connection mode
  input  wire logic              req,        // Pulse: request one conversion
  input  wire logic              shutdown,   // Level: hold converter powered down
  input  wire logic              deep,       // Pick sleep instead of nap
  output logic                   idle,       // Ready for a request
  output logic                   rdy,        // Pulse: result valid
  output logic [acc_pkg::DATA_W-1:0] result  // Captured result
);
  import acc_pkg::*;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_PULSE, ST_WAIT, ST_READ, ST_DOWN, ST_WAKE} acc_hst_t;
  acc_hst_t         st;
  logic [CNT_W-1:0] cnt;
  logic             pd_n, cs_n, rd_n, cv_n, was_deep, busy_q;

  wire tied     = mode == ACC_MODE_SLOWMEM || mode == ACC_MODE_ROM; // RULE13
  wire busy_rise = !busy_q && link.busy_n;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= ST_IDLE; cnt <= '0; pd_n <= 1'b1; cs_n <= 1'b1; rd_n <= 1'b1; cv_n <= 1'b1;
      was_deep <= 1'b0; busy_q <= 1'b1; idle <= 1'b0; rdy <= 1'b0; result <= DATA_RESET;
    end else begin
      busy_q <= link.busy_n;
      rdy    <= 1'b0;
      case (st)
        ST_IDLE: begin
          cs_n <= 1'b0;
          rd_n <= !(mode == ACC_MODE_FREE); // RULE11
          idle <= !shutdown;
          if (shutdown) begin
            // Select high at entry picks sleep, low picks nap
            cs_n     <= deep; // RULE6
            was_deep <= deep;
            st       <= ST_DOWN;
            idle     <= 1'b0;
          end else if (req) begin
            idle <= 1'b0; cv_n <= 1'b0; cnt <= '0; st <= ST_PULSE;
            if (tied) rd_n <= 1'b0; // RULE13 RULE17
          end
        end
        ST_PULSE: begin
          if (mode == ACC_MODE_SLOWMEM) begin
            st <= ST_WAIT; // RULE14 hold strobe
          end else if (cnt == CNT_W'(PULSE_LEN - 1)) begin
            cv_n <= 1'b1; st <= ST_WAIT;
            if (tied) begin
              rd_n <= 1'b1;
              result <= link.data_bus; // RULE17 previous result
            end
          end else begin
            cnt <= cnt + CNT_W'(1);
          end
        end
        ST_WAIT: if (busy_rise) begin // RULE18
          if (mode == ACC_MODE_SLOWMEM) begin
            cv_n <= 1'b1; rd_n <= 1'b1; result <= link.data_bus; rdy <= 1'b1; st <= ST_IDLE; // RULE14
          end else if (mode == ACC_MODE_READ) begin
            rd_n <= 1'b0; st <= ST_READ; // RULE12
          end else begin
            if (mode == ACC_MODE_FREE) result <= link.data_bus; // RULE11
            rdy <= 1'b1; st <= ST_IDLE;
          end
        end
        ST_READ: begin
          // Output enable is registered in the converter, so wait until it shows
          if (link.data_oe) begin // RULE12
            result <= link.data_bus;
            rd_n   <= 1'b1;
            rdy    <= 1'b1;
            st     <= ST_IDLE;
          end
        end
        ST_DOWN: begin
          pd_n <= 1'b0; // RULE5
          if (!shutdown && !pd_n) begin
            pd_n <= 1'b1;
            cnt <= was_deep ? CNT_W'(SLEEP_WAKE) : CNT_W'(NAP_WAKE); // RULE2 RULE4
            st <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (cnt == '0) st <= ST_IDLE;
          else cnt <= cnt - CNT_W'(1);
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  assign link.power_down_n       = pd_n;
  assign link.chip_select_n      = cs_n;
  assign link.read_n             = rd_n;
  assign link.conversion_start_n = cv_n;
endmodule : acc_host

//--- verification/acc_asserts.sv
// Checker watching the signals between the converter end and the bus master end
`timescale 1ns/1ns
module acc_asserts
  import acc_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES // Conversion length in cycles
) (
  input wire logic              sys_clk,            // Clock
  input wire logic              rst_n,              // Reset, active low
  input wire logic              power_down_n,       // Power-down request
  input wire logic              chip_select_n,      // Select
  input wire logic              read_n,             // Read strobe
  input wire logic              conversion_start_n, // Start strobe
  input wire logic              busy_n,             // Converting
  input wire logic [acc_pkg::DATA_W-1:0] data_out,  // Result
  input wire logic              data_oe             // Data driven
);
  localparam int CONV_MAX = CONV_MAX_CYCLES;
  int cnt;
  // Counts sampled low cycles of busy so long waits need no deep repetition
  always_ff @(posedge sys_clk) begin
    cnt <= (!rst_n || busy_n) ? 0 : cnt + 1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  start_cause_a: assert property ($fell(busy_n) |->
    $past(conversion_start_n) == 1'b0 && $past(chip_select_n) == 1'b0)
    else $error("busy fell with no start");
  busy_len_a: assert property ($rose(busy_n) |-> cnt == CONV_LEN)
    else $error("busy low for wrong length");
  busy_max_a: assert property (!busy_n |-> cnt < CONV_MAX)
    else $error("conversion too long");
  oe_on_a: assert property (!chip_select_n && !read_n |=> data_oe)
    else $error("data not driven");
  oe_off_a: assert property (chip_select_n || read_n |=> !data_oe)
    else $error("data driven without read");
  data_hold_a: assert property (!busy_n |-> $stable(data_out))
    else $error("data changed while converting");
  data_update_a: assert property (!$stable(data_out) |-> $rose(busy_n))
    else $error("data changed away from busy rise");
  pd_hold_a: assert property ((!power_down_n && busy_n) [*2] |=> busy_n)
    else $error("conversion in power-down");
  cover property ($rose(busy_n));
  cover property ($rose(data_oe));
  cover property ($fell(power_down_n));
endmodule : acc_asserts

//--- verification/acc_tb_top.sv
// Testbench joining both ends and driving the host user side
`timescale 1ns/1ns
module acc_tb_top;
  import acc_pkg::*;
  localparam int CONV_LEN = 180;
  localparam int NAP_W = 40;
  localparam int SLP_W = 50;
  logic              sys_clk, rst_n, req, shutdown, deep, idle, rdy;
  logic              sample_take, ref_on, analog_on, ready;
  acc_mode_t         mode;
  logic [DATA_W-1:0] result, sample_in, last, e;
  logic [DATA_W-1:0] q[$];
  int                n_errors, samples_checked, seed;
  acc_if acc_if_i ();
  acc_device #(.CONV_LEN(CONV_LEN), .NAP_WAKE(NAP_W), .SLEEP_WAKE(SLP_W)) acc_device_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(acc_if_i), .sample_in(sample_in),
    .sample_take(sample_take), .ref_on(ref_on), .analog_on(analog_on), .ready(ready));
  acc_host #(.NAP_WAKE(NAP_W), .SLEEP_WAKE(SLP_W)) acc_host_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(acc_if_i), .mode(mode), .req(req),
    .shutdown(shutdown), .deep(deep), .idle(idle), .rdy(rdy), .result(result));
  acc_asserts #(.CONV_LEN(CONV_LEN)) acc_asserts_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .power_down_n(acc_if_i.power_down_n),
    .chip_select_n(acc_if_i.chip_select_n), .read_n(acc_if_i.read_n),
    .conversion_start_n(acc_if_i.conversion_start_n), .busy_n(acc_if_i.busy_n),
    .data_out(acc_if_i.data_out), .data_oe(acc_if_i.data_oe));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [DATA_W-1:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_bit(input string what, input logic exp, got);
    chk(what, {13'h0000, exp}, {13'h0000, got});
  endtask : chk_bit
  task automatic test_done();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic give_up(input logic ok);
    if (ok !== 1'b1) begin
      n_errors++;
      test_done();
    end
  endtask : give_up
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick
  // One conversion with a refused request in its middle
  task automatic conv(input acc_mode_t m);
    int i;
    logic [DATA_W-1:0] old;
    mode = m;
    for (i = 0; i < 100 && idle !== 1'b1; i++) tick();
    give_up(idle);
    old = last;
    sample_in = 14'($urandom);
    q.push_back(m == ACC_MODE_ROM ? old : sample_in);
    last = sample_in;
    req = 1'b1;
    tick();
    req = 1'b0;
    repeat (5) tick();
    if (m == ACC_MODE_READ) chk_bit("oe", 1'b0, acc_if_i.data_oe);
    if (m == ACC_MODE_FREE) chk_bit("oe", 1'b1, acc_if_i.data_oe);
    if (m == ACC_MODE_SLOWMEM) chk("prev", old, acc_if_i.data_bus);
    req = 1'b1;
    tick();
    req = 1'b0;
    for (i = 0; i < 1000 && q.size() != 0; i++) tick();
    give_up(q.size() == 0);
  endtask : conv
  task automatic pwr(input logic d);
    int i;
    deep = d;
    shutdown = 1'b1;
    for (i = 0; i < 50 && ready !== 1'b0; i++) tick();
    give_up(ready === 1'b0);
    repeat (3) tick();
    chk_bit("analog", 1'b0, analog_on);
    chk_bit("ref", ~d, ref_on);
    chk_bit("busy", 1'b1, acc_if_i.busy_n);
    shutdown = 1'b0;
    for (i = 0; i < 50 && acc_if_i.power_down_n !== 1'b1; i++) tick();
    give_up(acc_if_i.power_down_n === 1'b1);
    for (i = 0; i < 200 && ready !== 1'b1; i++) tick();
    chk("wake", 14'(d ? SLP_W + 2 : NAP_W + 2), 14'(i));
    give_up(ready === 1'b1);
  endtask : pwr
  // ------------------------------------------------------------
  // Clock, result watcher and main sequence
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    // Sample hold pulse and busy fall come from the same taken start
    if (rst_n === 1'b1 && sample_take === 1'b1) begin
      chk_bit("take", 1'b0, acc_if_i.busy_n);
    end
    if (rst_n === 1'b1 && rdy === 1'b1) begin
      if (q.size() == 0) begin
        n_errors++;
        $display("BAD rdy expected none seen %h", result);
      end else begin
        e = q.pop_front();
        chk("result", e, result);
        if (mode == ACC_MODE_FREE) chk("bus", e, acc_if_i.data_bus);
      end
    end
  end
  initial begin
    rst_n = 1'b0;
    req = 1'b0;
    shutdown = 1'b0;
    deep = 1'b0;
    mode = ACC_MODE_FREE;
    sample_in = 14'h0000;
    last = 14'h0000;
    n_errors = 0;
    samples_checked = 0;
    seed = $urandom(18);
    repeat (10) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    for (int r = 0; r < 2; r++) begin
      for (int m = 0; m < 4; m++) begin
        conv(acc_mode_t'(m));
        conv(acc_mode_t'(m));
      end
      pwr(r[0]);
    end
    test_done();
  end
endmodule : acc_tb_top
